/* hw/rfbs_pkg.sv */
// package: constants and types for the raster frame buffer fetch and subpanel block
package rfbs_pkg;
    // pixel type identifiers held in the first palette entry (bits 14:12)
    localparam logic [2:0] PIX_TYPE_ONE_BIT = 3'h0;
    localparam logic [2:0] PIX_TYPE_TWO_BIT = 3'h1;
    localparam logic [2:0] PIX_TYPE_FOUR_BIT = 3'h2;
    localparam logic [2:0] PIX_TYPE_EIGHT_BIT = 3'h3;
    localparam logic [2:0] PIX_TYPE_DIRECT_COLOUR = 3'h4;
    localparam int PIX_TYPE_LSB = 12;
    // palette block sizes in words
    localparam logic [7:0] PAL_WORDS_SMALL = 8'h08;
    localparam logic [7:0] PAL_WORDS_LARGE = 8'h80;
    // direct colour formats from the raster configuration
    localparam logic [1:0] DIRECT_FMT_12 = 2'h0;
    localparam logic [1:0] DIRECT_FMT_16 = 2'h1;
    localparam logic [1:0] DIRECT_FMT_24 = 2'h2;
    // reset values
    localparam logic [23:0] DEFAULT_COLOUR_RST = 24'h000000;
    localparam logic [11:0] PAL_ENTRY_RST = 12'h000;
    // fetch engine states
    typedef enum logic [2:0] {RFBS_IDLE, RFBS_REQ, RFBS_WAIT, RFBS_SKIP, RFBS_EOF} rfbs_state_t;
endpackage : rfbs_pkg

/* hw/rfbs_pix_if.sv */
// interface: one fetched word with its role, passed from fetch engine to unpacker
`timescale 1ns/1ps
`default_nettype none
interface rfbs_pix_if;
    logic valid; // word strobe
    logic is_pal; // word belongs to palette block
    logic [6:0] pal_idx; // word index inside palette block
    logic [31:0] data; // word data
    modport src (output valid, output is_pal, output pal_idx, output data);
    modport dst (input valid, input is_pal, input pal_idx, input data);
endinterface : rfbs_pix_if
`default_nettype wire

/* hw/rfbs_unpack.sv */
// unpacker: palette storage, pixel type capture and first-pixel decode of each word
`timescale 1ns/1ps
`default_nettype none
module rfbs_unpack
    import rfbs_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset,
    rfbs_pix_if.dst word_in,
    input wire logic i_reverse_pixel_order,
    input wire logic [1:0] i_direct_fmt,
    output logic [2:0] o_pix_type,
    output logic [23:0] o_pixel,
    output logic o_pixel_valid
);
    // palette held in flip-flops, 256 entries of 12-bit colour
    logic [11:0] palette [256];
    logic [2:0] pix_type;
    logic [7:0] first_idx;
    logic [11:0] look;
    logic [23:0] next_pixel;

    // leftmost pixel taken from lsbs by default, msbs when reversed
    always_comb
    begin
        first_idx = 8'h00;
        unique case (pix_type)
            PIX_TYPE_ONE_BIT: first_idx = i_reverse_pixel_order ? {7'h00, word_in.data[31]} : {7'h00, word_in.data[0]};
            PIX_TYPE_TWO_BIT: first_idx = i_reverse_pixel_order ? {6'h00, word_in.data[31:30]} : {6'h00, word_in.data[1:0]};
            PIX_TYPE_FOUR_BIT: first_idx = i_reverse_pixel_order ? {4'h0, word_in.data[31:28]} : {4'h0, word_in.data[3:0]};
            default: first_idx = i_reverse_pixel_order ? word_in.data[31:24] : word_in.data[7:0];
        endcase
    end
    assign look = palette[first_idx];

    // direct colour bypasses the table; format from raster configuration
    always_comb
    begin
        next_pixel = {look[11:8], 4'h0, look[7:4], 4'h0, look[3:0], 4'h0};
        if (pix_type == PIX_TYPE_DIRECT_COLOUR)
        begin
            unique case (i_direct_fmt)
                DIRECT_FMT_12: next_pixel = {word_in.data[11:8], 4'h0, word_in.data[7:4], 4'h0, word_in.data[3:0], 4'h0};
                DIRECT_FMT_16: next_pixel = {word_in.data[15:11], 3'h0, word_in.data[10:5], 2'h0, word_in.data[4:0], 3'h0};
                default: next_pixel = word_in.data[23:0];
            endcase
        end
    end

    // palette words store two halfword entries; entry 0 also carries the type
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            pix_type <= PIX_TYPE_ONE_BIT;
            o_pixel <= DEFAULT_COLOUR_RST;
            o_pixel_valid <= 1'b0;
            for (int k = 0; k < 256; k++)
                palette[k] <= PAL_ENTRY_RST;
        end
        else
        begin
            o_pixel_valid <= word_in.valid && !word_in.is_pal;
            if (word_in.valid && word_in.is_pal)
            begin
                palette[{word_in.pal_idx, 1'b0}] <= word_in.data[11:0];
                palette[{word_in.pal_idx, 1'b1}] <= word_in.data[27:16];
                if (word_in.pal_idx == 7'h00)
                    pix_type <= word_in.data[PIX_TYPE_LSB +: 3];
            end
            else if (word_in.valid)
                o_pixel <= next_pixel;
        end
    end
    assign o_pix_type = pix_type;
endmodule : rfbs_unpack
`default_nettype wire

/* hw/rfbs_top.sv */
// top: frame buffer fetch engine with ping-pong buffers, palette skip and subpanel fill
//
// How it works
// - two buffers; buffer 1 only when alternating
// - pixels-only load keeps last palette
// - otherwise palette block precedes pixels
// - 128 words for 8-bit, else 8
// - direct colour still skips 8 words
// - type identifier from first palette entry
// - palette entries are 12-bit colour halfwords
// - entries used depend on pixel depth
// - direct colour bypasses the lookup table
// - subpanel fills default colour without fetches
// - subpanel only in active raster mode
// - line count sets bottom part height
// - default colour is 24-bit rgb
// - separate enable bit activates subpanel
// - disable finishes frame then frame-done
// - leftmost pixel lsbs, or msbs reversed
`timescale 1ns/1ps
`default_nettype none
module rfbs_top
    import rfbs_pkg::*;
#(
    parameter int ADDR_W = 32, // memory address width
    parameter int LINE_W = 11 // line counter width
)
(
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_raster_enable, // raster output on
    input wire logic i_raster_mode, // raster rather than character mode
    input wire logic i_active_matrix, // panel is active matrix
    input wire logic i_dual_buffer_alternate, // ping-pong between buffers
    input wire logic i_pixels_only, // frame buffer holds pixels only
    input wire logic i_reverse_pixel_order,
    input wire logic [1:0] i_direct_fmt, // direct colour format
    input wire logic [ADDR_W-1:0] i_fb_base_0,
    input wire logic [ADDR_W-1:0] i_fb_len_0, // bytes
    input wire logic [ADDR_W-1:0] i_fb_base_1,
    input wire logic [ADDR_W-1:0] i_fb_len_1,
    input wire logic [LINE_W-1:0] i_lines_per_frame, // total panel lines
    input wire logic [ADDR_W-1:0] i_words_per_line, // image words per line
    input wire logic i_subpanel_enable,
    input wire logic i_image_area_upper, // 1 image on top, 0 image at bottom
    input wire logic [LINE_W-1:0] i_bottom_lines,
    input wire logic [23:0] i_default_colour,
    input wire logic i_mem_ack, // memory accepted and returned a word
    input wire logic [31:0] i_mem_rdata,
    output logic o_mem_req,
    output logic [ADDR_W-1:0] o_mem_addr,
    output logic [23:0] o_pixel,
    output logic o_pixel_valid,
    output logic o_fill_valid, // one-cycle strobe per default colour fill line
    output logic o_frame_done_event, // one-cycle pulse, engine stopped
    output logic o_buffer_sel,
    output logic [2:0] o_pix_type
);
    // the 128-word palette length needs eight address bits; refuse narrower builds at elaboration
    if (ADDR_W < 8 || LINE_W < 1)
    begin : g_param_check
        $error("rfbs_top: unsupported parameter values");
    end

    rfbs_state_t state;
    rfbs_state_t next_state;
    logic buf_sel; // buffer being fetched
    logic [ADDR_W-1:0] word_cnt; // words fetched this frame
    logic [ADDR_W-1:0] line_word; // words within current line
    logic [LINE_W-1:0] line_cnt; // current line
    logic [31:0] cap_data;
    logic cap_valid;
    logic cap_is_pal;
    logic [6:0] cap_idx;

    // selected buffer; buffer 1 only when alternating
    wire logic use_buf1 = buf_sel && i_dual_buffer_alternate;
    wire logic [ADDR_W-1:0] base_sel = use_buf1 ? i_fb_base_1 : i_fb_base_0;
    wire logic [ADDR_W-1:0] len_words = (use_buf1 ? i_fb_len_1 : i_fb_len_0) >> 2;
    // palette block length from type; none when pixels only
    wire logic [7:0] pal_words = (o_pix_type == PIX_TYPE_EIGHT_BIT) ? PAL_WORDS_LARGE : PAL_WORDS_SMALL;
    wire logic [ADDR_W-1:0] pal_len = i_pixels_only ? '0 : ADDR_W'(pal_words);
    wire logic in_pal = word_cnt < pal_len;
    // subpanel active only in active-matrix raster mode with its own enable
    wire logic sub_on = i_subpanel_enable && i_raster_mode && i_active_matrix;
    wire logic [LINE_W-1:0] top_lines = i_lines_per_frame - i_bottom_lines;
    wire logic fill_line = sub_on && (i_image_area_upper ? (line_cnt >= top_lines) : (line_cnt < top_lines));
    wire logic last_line = line_cnt == i_lines_per_frame - LINE_W'(1);
    wire logic frame_over = line_cnt >= i_lines_per_frame; // every line scanned, even if length remains
    wire logic fetch_done = word_cnt >= len_words;
    wire logic line_end = !in_pal && (line_word + ADDR_W'(1) >= i_words_per_line);

    // next state: fill lines skip memory, fetch stops at length
    always_comb
    begin
        next_state = state;
        unique case (state)
            RFBS_IDLE: next_state = (i_raster_enable && i_raster_mode) ? RFBS_REQ : RFBS_IDLE;
            RFBS_REQ:
            begin
                if (frame_over)
                    next_state = RFBS_EOF;
                else if (!in_pal && fill_line)
                    next_state = RFBS_SKIP;
                else if (fetch_done)
                    next_state = RFBS_SKIP;
                else
                    next_state = RFBS_WAIT;
            end
            RFBS_WAIT: next_state = i_mem_ack ? RFBS_REQ : RFBS_WAIT;
            RFBS_SKIP: next_state = last_line ? RFBS_EOF : RFBS_REQ;
            RFBS_EOF: next_state = i_raster_enable ? RFBS_REQ : RFBS_IDLE;
        endcase
    end

    // state, counters and memory request
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state <= RFBS_IDLE;
            buf_sel <= 1'b0;
            word_cnt <= '0;
            line_word <= '0;
            line_cnt <= '0;
            o_mem_req <= 1'b0;
            o_mem_addr <= '0;
            o_fill_valid <= 1'b0;
            o_frame_done_event <= 1'b0;
            o_buffer_sel <= 1'b0;
        end
        else
        begin
            state <= next_state;
            o_frame_done_event <= 1'b0;
            o_fill_valid <= (state == RFBS_SKIP) && fill_line;
            if (state == RFBS_REQ && next_state == RFBS_WAIT)
            begin
                o_mem_req <= 1'b1;
                o_mem_addr <= {base_sel[ADDR_W-1:2], 2'b00} + (word_cnt << 2);
            end
            if (state == RFBS_WAIT && i_mem_ack)
            begin
                o_mem_req <= 1'b0;
                word_cnt <= word_cnt + ADDR_W'(1);
                line_word <= line_end ? '0 : (in_pal ? line_word : line_word + ADDR_W'(1));
                if (line_end)
                    line_cnt <= line_cnt + LINE_W'(1);
            end
            if (state == RFBS_SKIP)
                line_cnt <= line_cnt + LINE_W'(1);
            if (state == RFBS_EOF)
            begin
                word_cnt <= '0;
                line_cnt <= '0;
                line_word <= '0;
                buf_sel <= i_dual_buffer_alternate ? !buf_sel : 1'b0;
                o_buffer_sel <= i_dual_buffer_alternate ? !buf_sel : 1'b0;
                o_frame_done_event <= !i_raster_enable;
            end
        end
    end

    // captured word with its role for the unpacker
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            cap_valid <= 1'b0;
            cap_is_pal <= 1'b0;
            cap_idx <= 7'h00;
            cap_data <= 32'h00000000;
        end
        else
        begin
            cap_valid <= (state == RFBS_WAIT) && i_mem_ack;
            cap_is_pal <= in_pal;
            cap_idx <= word_cnt[6:0];
            cap_data <= i_mem_rdata;
        end
    end

    rfbs_pix_if word_bus ();
    assign word_bus.valid = cap_valid;
    assign word_bus.is_pal = cap_is_pal;
    assign word_bus.pal_idx = cap_idx;
    assign word_bus.data = cap_data;

    logic [23:0] img_pixel;
    logic img_valid;
    rfbs_unpack u_unpack (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .word_in(word_bus),
        .i_reverse_pixel_order(i_reverse_pixel_order),
        .i_direct_fmt(i_direct_fmt),
        .o_pix_type(o_pix_type),
        .o_pixel(img_pixel),
        .o_pixel_valid(img_valid)
    );

    // output mux: default 24-bit colour on fill lines, image otherwise
    // the fill pixel trails its skip state by two cycles, clear of the last image pixel
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_pixel <= DEFAULT_COLOUR_RST;
            o_pixel_valid <= 1'b0;
        end
        else
        begin
            o_pixel_valid <= img_valid || o_fill_valid;
            if (o_fill_valid)
                o_pixel <= i_default_colour;
            else if (img_valid)
                o_pixel <= img_pixel;
        end
    end
endmodule : rfbs_top
`default_nettype wire

/* sim/rfbs_assertions.sv */
// checker: fetch handshake, frame end and subpanel gating of the raster fetch block
`timescale 1ns/1ps
`default_nettype none
module rfbs_assertions
    import rfbs_pkg::*;
#(
    parameter int ADDR_W = 32
)
(
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_raster_enable,
    input wire logic i_raster_mode,
    input wire logic i_active_matrix,
    input wire logic i_dual_buffer_alternate,
    input wire logic i_subpanel_enable,
    input wire logic [ADDR_W-1:0] i_fb_base_0,
    input wire logic [ADDR_W-1:0] i_fb_base_1,
    input wire logic i_mem_ack,
    input wire logic o_mem_req,
    input wire logic [ADDR_W-1:0] o_mem_addr,
    input wire logic o_fill_valid,
    input wire logic o_frame_done_event,
    input wire logic o_buffer_sel
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    logic [ADDR_W-1:0] last_addr; // address of the last word taken
    logic seen; // a word has been taken since reset
    // remember the last taken address so the next one can be judged
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            last_addr <= '0;
            seen <= 1'b0;
        end
        else if (o_mem_req && i_mem_ack)
        begin
            last_addr <= o_mem_addr;
            seen <= 1'b1;
        end
    end
    property p_req_hold; o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr); endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped before ack");
    property p_addr_align; o_mem_req |-> o_mem_addr[1:0] == 2'h0; endproperty
    a_addr_align: assert property (p_addr_align) else $error("unaligned fetch address");
    property p_req_drop; o_mem_req && i_mem_ack |=> !o_mem_req; endproperty
    a_req_drop: assert property (p_req_drop) else $error("request stands after ack");
    // a new request either steps one word on or restarts at a buffer base
    property p_addr_step;
        $rose(o_mem_req) && seen |-> o_mem_addr == last_addr + 4 ||
            o_mem_addr == {i_fb_base_0[ADDR_W-1:2], 2'h0} || o_mem_addr == {i_fb_base_1[ADDR_W-1:2], 2'h0};
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("fetch address out of order");
    property p_done_pulse; o_frame_done_event |=> !o_frame_done_event; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("frame done longer than one cycle");
    property p_done_cause; o_frame_done_event |-> !$past(i_raster_enable); endproperty
    a_done_cause: assert property (p_done_cause) else $error("frame done while enabled");
    property p_fill_no_req; o_fill_valid |-> !o_mem_req; endproperty
    a_fill_no_req: assert property (p_fill_no_req) else $error("fetch during fill line");
    property p_fill_mode; o_fill_valid |-> $past(i_subpanel_enable) && $past(i_raster_mode && i_active_matrix); endproperty
    a_fill_mode: assert property (p_fill_mode) else $error("fill outside subpanel mode");
    property p_buf_alt; $rose(o_buffer_sel) |-> $past(i_dual_buffer_alternate); endproperty
    a_buf_alt: assert property (p_buf_alt) else $error("buffer switch without alternating");
    c_fill: cover property (o_fill_valid);
    c_done: cover property (o_frame_done_event);
    c_buf: cover property ($rose(o_buffer_sel));
endmodule : rfbs_assertions
bind rfbs_top rfbs_assertions #(.ADDR_W(ADDR_W)) chk_u (.*);
`default_nettype wire

/* sim/rfbs_mem_model.sv */
// partner: frame buffer memory answering word requests, alternately prompt and slow
`timescale 1ns/1ps
`default_nettype none
module rfbs_mem_model
(
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_mem_req,
    input wire logic [31:0] i_mem_addr,
    output logic o_mem_ack,
    output logic [31:0] o_mem_rdata
);
    logic [31:0] mem [0:1023]; // word storage, preset to its index, some words set by the bench
    logic [1:0] wait_cnt; // cycles waited on this request
    logic slow; // toggles the answer latency per word
    initial for (int i = 0; i < 1024; i++) mem[i] = 32'h0 + i;
    // answer after 0 or 2 wait cycles; rdata scrambles when idle so stale data never looks valid
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_mem_ack <= 1'b0;
            o_mem_rdata <= 32'h0;
            wait_cnt <= 2'h0;
            slow <= 1'b0;
        end
        else if (i_mem_req && !o_mem_ack)
        begin
            if (wait_cnt == (slow ? 2'h2 : 2'h0))
            begin
                o_mem_ack <= 1'b1;
                o_mem_rdata <= mem[i_mem_addr[11:2]];
                wait_cnt <= 2'h0;
                slow <= !slow;
            end
            else
                wait_cnt <= wait_cnt + 2'h1;
        end
        else
        begin
            o_mem_ack <= 1'b0;
            o_mem_rdata <= ~o_mem_rdata;
        end
    end
endmodule : rfbs_mem_model
`default_nettype wire

/* sim/rfbs_top_tb.sv */
// testbench: frame fetch counts, palette sizing, subpanel fill and buffer alternation
`timescale 1ns/1ps
`default_nettype none
module rfbs_top_tb
    import rfbs_pkg::*;
;
    logic clk = 0, rst = 1, en = 0, rmode = 1, am = 1, dual = 0, ponly = 0, rev = 0, sub_en = 0, upper = 1;
    logic [1:0] dfmt = 2'h2;
    logic [31:0] base0 = 32'h102, len0 = 32'h0, base1 = 32'h800, len1 = 32'h50, wpl = 32'h4;
    logic [10:0] lines = 11'h3, bot = 11'h1;
    logic [23:0] defc = 24'hA5C3E1, pixel, first_pix;
    logic ack, req, pv, fv, done, bsel;
    logic [31:0] rdata, addr, first_addr, prev_addr;
    logic [2:0] ptype;
    int failures = 0, checks = 0, fetch_n, fill_n, step_err, pix_n, def_n;
    always #4 clk = ~clk;
    rfbs_top dut_u (.i_ref_clk(clk), .i_reset(rst), .i_raster_enable(en), .i_raster_mode(rmode),
        .i_active_matrix(am), .i_dual_buffer_alternate(dual), .i_pixels_only(ponly), .i_reverse_pixel_order(rev),
        .i_direct_fmt(dfmt), .i_fb_base_0(base0), .i_fb_len_0(len0), .i_fb_base_1(base1), .i_fb_len_1(len1),
        .i_lines_per_frame(lines), .i_words_per_line(wpl), .i_subpanel_enable(sub_en), .i_image_area_upper(upper),
        .i_bottom_lines(bot), .i_default_colour(defc), .i_mem_ack(ack), .i_mem_rdata(rdata), .o_mem_req(req),
        .o_mem_addr(addr), .o_pixel(pixel), .o_pixel_valid(pv), .o_fill_valid(fv), .o_frame_done_event(done),
        .o_buffer_sel(bsel), .o_pix_type(ptype));
    rfbs_mem_model mem_u (.i_ref_clk(clk), .i_reset(rst), .i_mem_req(req), .i_mem_addr(addr), .o_mem_ack(ack),
        .o_mem_rdata(rdata));
    // watch taken words and fill lines; values before the edge are the sampled ones
    always @(posedge clk)
    begin
        if (req === 1'b1 && ack === 1'b1)
        begin
            if (fetch_n == 0) first_addr = addr;
            else if (addr !== prev_addr + 4) step_err++;
            prev_addr = addr;
            fetch_n++;
        end
        if (fv === 1'b1) fill_n++;
        if (pv === 1'b1)
        begin
            if (pix_n == 0) first_pix = pixel;
            if (pixel === defc) def_n++;
            pix_n++;
        end
    end
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk_val
    // one frame: pulse enable so the engine finishes this frame and reports done
    task automatic run_frame(input int words);
        int n;
        fetch_n = 0;
        fill_n = 0;
        step_err = 0;
        pix_n = 0;
        def_n = 0;
        @(posedge clk);
        len0 <= words * 4;
        en <= 1'b1;
        @(posedge clk);
        en <= 1'b0;
        for (n = 0; n < 5000 && done !== 1'b1; n++) @(posedge clk) #1;
        if (n == 5000)
        begin
            failures++;
            report_and_stop;
        end
        // the last pixel of a frame leaves in the same cycle as done; let the watcher count it
        repeat (2) @(posedge clk) #1;
    endtask : run_frame
    // every type code with its palette size; base low bits must be dropped
    task automatic s_palette_sizes;
        logic [2:0] ty [5] = '{PIX_TYPE_ONE_BIT, PIX_TYPE_TWO_BIT, PIX_TYPE_FOUR_BIT, PIX_TYPE_EIGHT_BIT,
            PIX_TYPE_DIRECT_COLOUR};
        int pal [5] = '{8, 8, 8, 128, 8};
        // first pixel word 84000001h, entry 1 is 5A3h: colour per type and read order
        logic [23:0] pix [5] = '{24'h50A030, 24'h004010, 24'h50A030, 24'h008020, 24'h000001};
        for (int k = 0; k < 5; k++)
        begin
            mem_u.mem[64] = {4'h0, 12'h5A3, 1'b0, ty[k], 12'h0};
            mem_u.mem[64 + pal[k]] = 32'h84000001;
            rev <= k[0];
            run_frame(pal[k] + 12);
            chk_val(fetch_n, pal[k] + 12, "fetch count");
            chk_val(first_pix, pix[k], "first pixel");
            chk_val(pix_n, 12, "pixel count");
            chk_val(ptype, ty[k], "pixel type");
            chk_val(first_addr, 32'h100, "first address");
            chk_val(step_err, 0, "address steps");
        end
    endtask : s_palette_sizes
    // pixels only: no palette words, type kept from the last palette
    task automatic s_pixels_only;
        mem_u.mem[64] = {17'h0, PIX_TYPE_EIGHT_BIT, 12'h0};
        ponly <= 1'b1;
        run_frame(12);
        chk_val(fetch_n, 12, "pixels only count");
        chk_val(ptype, PIX_TYPE_DIRECT_COLOUR, "kept type");
        chk_val(first_pix, 24'h003000, "pixels only first pixel");
        ponly <= 1'b0;
    endtask : s_pixels_only
    // subpanel both ways, then gated by panel kind and by the enable bit
    task automatic s_subpanel;
        logic [4:0] cfg [4] = '{5'h1D, 5'h19, 5'h0D, 5'h15}; // am, sub_en, upper, bot
        int exp_fetch [4] = '{16, 12, 20, 20};
        int exp_fill [4] = '{1, 2, 0, 0};
        mem_u.mem[64] = {17'h0, PIX_TYPE_FOUR_BIT, 12'h0};
        for (int k = 0; k < 4; k++)
        begin
            {am, sub_en, upper} <= cfg[k][4:2];
            bot <= {9'h0, cfg[k][1:0]};
            run_frame(exp_fetch[k]);
            chk_val(fetch_n, exp_fetch[k], "subpanel fetches");
            chk_val(fill_n, exp_fill[k], "fill lines");
            chk_val(def_n, exp_fill[k], "default colour pixels");
            chk_val(pix_n, exp_fetch[k] - 8 + exp_fill[k], "pixels shown");
        end
        sub_en <= 1'b0;
    endtask : s_subpanel
    // alternating buffers: the second frame comes from buffer 1
    task automatic s_dual;
        mem_u.mem[512] = {17'h0, PIX_TYPE_TWO_BIT, 12'h0};
        dual <= 1'b1;
        run_frame(20);
        chk_val(bsel, 1, "buffer select");
        run_frame(20);
        chk_val(first_addr, 32'h800, "second buffer base");
        chk_val(ptype, PIX_TYPE_TWO_BIT, "second buffer type");
    endtask : s_dual
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        s_palette_sizes;
        s_pixels_only;
        s_subpanel;
        s_dual;
        report_and_stop;
    end
endmodule : rfbs_top_tb
`default_nettype wire
